/* dltr_pkg.sv */
// ===========================================================
// shared constants and carrier types
package dltr_pkg;

   // register offsets
   localparam logic [7:0] ADDR_CAL = 8'h19;
   localparam logic [7:0] ADDR_TERM = 8'h1A;
   localparam logic [7:0] ADDR_RSVD27 = 8'h1B;
   localparam logic [7:0] ADDR_LOOP = 8'h1C;
   localparam logic [7:0] ADDR_VOLT = 8'h1D;

   // calibration register fields
   localparam int CAL_BUSY_BIT = 7;
   localparam int CAL_MAN_BIT = 6;
   localparam int CAL_DIS_BIT = 5;
   localparam int CAL_RSVD_BIT = 4;
   localparam int CAL_TRIM_LSB = 0;
   localparam int CAL_TRIM_W = 4;

   // termination register fields
   localparam int TERM_DCV_LSB = 6;
   localparam int TERM_MINI_LSB = 4;
   localparam int TERM_CURRENT_LIMIT_ENABLE_BIT = 1;
   localparam int TERM_DCR_BIT = 0;

   // reset values
   localparam logic [7:0] TERM_RESET = 8'h00;
   localparam logic [7:0] MEAS_RESET = 8'h00;
   localparam logic [3:0] TRIM_RESET = 4'h8;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // analog targets per code
   localparam logic [11:0] DCT_MV [4] =
      '{12'hC1C, 12'hC80, 12'hD16, 12'hDAC}; // 3100 3200 3350 3500
   localparam logic [4:0] MIN_LOOP_MA [4] =
      '{5'h0A, 5'h0C, 5'h0E, 5'h10}; // 10 12 14 16
   localparam logic [6:0] CURRENT_LIMIT_ENABLE_MA = 7'h3C; // 60 mA cap
   localparam logic [6:0] NO_LIMIT_MA = 7'h00;

   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int CAL_REQ_MAX_US = 1;  // ms window given in ms below
   localparam int CAL_REQ_MAX_MS = 1;
   localparam int CAL_REQ_MAX_CYC =
      (CAL_REQ_MAX_MS * 1000000) / CLK_PERIOD_NS;

   // register access request and answer
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dltr_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } dltr_rsp_t;

   // termination settings driven to the line side
   typedef struct packed {
      logic [1:0] line_voltage_adjust;
      logic [1:0] min_loop_current_sel;
      logic current_limit_enable;
      logic dc_impedance_sel;
   } dltr_term_t;

   // measurement pair
   typedef struct packed {
      logic [7:0] loop_current_value;
      logic [7:0] line_voltage_value;
   } dltr_meas_t;

   // calibration sequencer states
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b01,
      CAL_RUN = 2'b10
   } dltr_cal_st_t;

endpackage

/* dltr_meas_sync.sv */
`timescale 1ns/1ps
// ===========================================================
// brings line-side measurements into the core clock domain
module dltr_meas_sync
   import dltr_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic meas_toggle,
   input wire dltr_meas_t meas_raw,
   output dltr_meas_t meas,
   output logic meas_update
);

   typedef struct packed {
      logic [2:0] tog;
      dltr_meas_t d1;
      dltr_meas_t d2;
      dltr_meas_t meas;
      logic update;
   } dltr_sync_t;

   dltr_sync_t st;
   dltr_sync_t next_st;

   // ===========================================================
   // synchroniser and capture
   // data pass two flops; the toggle passes three, so the words
   // are settled when the toggle edge is seen
   always_comb begin
      next_st = st;
      next_st.tog = {st.tog[1:0], meas_toggle};
      next_st.d1 = meas_raw;
      next_st.d2 = st.d1;
      next_st.update = st.tog[2] ^ st.tog[1];
      if (st.tog[2] ^ st.tog[1]) begin
         next_st.meas = st.d2;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st <= '0;
         st.meas <= {MEAS_RESET, MEAS_RESET};
      end else begin
         st <= next_st;
      end
   end

   assign meas = st.meas;
   assign meas_update = st.update;

endmodule // dltr_meas_sync

/* dltr_regs.sv */
`timescale 1ns/1ps
module dltr_regs
   import dltr_pkg::*;
#(
   parameter int CAL_CYCLES = 400
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire dltr_req_t req,
   output dltr_rsp_t rsp,
   input wire logic meas_toggle,
   input wire dltr_meas_t meas_raw,
   output dltr_term_t term,
   output logic [11:0] dct_target_mv,
   output logic [4:0] min_loop_ma,
   output logic [6:0] loop_limit_ma,
   output logic cal_run,
   output logic [3:0] cal_trim_value,
   output logic loop_current_low,
   output logic line_absent,
   output logic polarity_reversal
);

   // ===========================================================
   // elaboration checks
   if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_cal
      $error("CAL_CYCLES must be 1 to 65535");
   end

   typedef struct packed {
      dltr_cal_st_t cal_st;
      logic [15:0] cal_cnt;
      logic [15:0] run_len; // cycles spent running, for the checks
      logic auto_pending;
      logic manual_cal_request;
      logic cal_disable;
      logic cal_rsvd;
      logic [3:0] cal_trim_value;
      dltr_term_t term;
      dltr_rsp_t rsp;
      logic [11:0] dct_target_mv;
      logic [4:0] min_loop_ma;
      logic [6:0] loop_limit_ma;
      logic have_sample;
      logic last_sign;
      logic polarity_reversal;
      logic loop_current_low;
      logic line_absent;
   } dltr_state_t;

   localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

   dltr_state_t st;
   dltr_state_t next_st;
   dltr_meas_t meas;
   logic meas_update;
   logic wr_cal;
   logic wr_term;
   logic man_rise;
   logic [7:0] cal_rd;
   logic [7:0] term_rd;

   // ===========================================================
   // measurement capture
   dltr_meas_sync u_meas (
      .core_clk(core_clk),
      .resetn(resetn),
      .meas_toggle(meas_toggle),
      .meas_raw(meas_raw),
      .meas(meas),
      .meas_update(meas_update)
   );

   // ===========================================================
   // write decode and read images
   assign wr_cal = req.wr && (req.addr == ADDR_CAL);
   assign wr_term = req.wr && (req.addr == ADDR_TERM);
   // manual request taken on its 0 to 1 transition only
   assign man_rise = wr_cal && req.wdata[CAL_MAN_BIT]
      && !st.manual_cal_request;

   // calibration register as read back
   always_comb begin
      cal_rd = ZERO_BYTE;
      cal_rd[CAL_BUSY_BIT] = (st.cal_st == CAL_RUN);
      cal_rd[CAL_MAN_BIT] = st.manual_cal_request;
      cal_rd[CAL_DIS_BIT] = st.cal_disable;
      cal_rd[CAL_RSVD_BIT] = st.cal_rsvd;
      cal_rd[CAL_TRIM_LSB +: CAL_TRIM_W] = st.cal_trim_value;
   end

   // termination register as read back, bits 3:2 read zero
   always_comb begin
      term_rd = ZERO_BYTE;
      term_rd[TERM_DCV_LSB +: 2] = st.term.line_voltage_adjust;
      term_rd[TERM_MINI_LSB +: 2] = st.term.min_loop_current_sel;
      term_rd[TERM_CURRENT_LIMIT_ENABLE_BIT] = st.term.current_limit_enable;
      term_rd[TERM_DCR_BIT] = st.term.dc_impedance_sel;
   end

   // ===========================================================
   // next state
   always_comb begin
      next_st = st;

      // calibration register writes; busy bit is not writable
      if (wr_cal) begin
         next_st.manual_cal_request = req.wdata[CAL_MAN_BIT];
         next_st.cal_disable = req.wdata[CAL_DIS_BIT];
         next_st.cal_rsvd = req.wdata[CAL_RSVD_BIT];
         next_st.cal_trim_value =
            req.wdata[CAL_TRIM_LSB +: CAL_TRIM_W];
      end

      // termination writes; reserved bits 3:2 are not stored
      if (wr_term) begin
         next_st.term.line_voltage_adjust =
            req.wdata[TERM_DCV_LSB +: 2];
         next_st.term.min_loop_current_sel =
            req.wdata[TERM_MINI_LSB +: 2];
         next_st.term.current_limit_enable =
            req.wdata[TERM_CURRENT_LIMIT_ENABLE_BIT];
         next_st.term.dc_impedance_sel = req.wdata[TERM_DCR_BIT];
      end
      // writes to 0x1B, 0x1C, 0x1D fall through here
      // and change nothing

      // calibration sequencer
      case (st.cal_st)
         CAL_IDLE: begin
            next_st.cal_cnt = '0;
            if (man_rise) begin
               next_st.cal_st = CAL_RUN;
            end else if (st.auto_pending && !next_st.cal_disable) begin
               next_st.cal_st = CAL_RUN;
               next_st.auto_pending = 1'b0;
            end else if (next_st.cal_disable) begin
               next_st.auto_pending = 1'b0;
            end
         end
         CAL_RUN: begin
            next_st.cal_cnt = st.cal_cnt + 16'h0001;
            if (st.cal_cnt >= CAL_LAST) begin
               next_st.cal_st = CAL_IDLE;
            end
         end
         default: begin
            next_st.cal_st = CAL_IDLE;
         end
      endcase

      // run length kept apart from the sequencer's own counter
      next_st.run_len = '0;
      if (st.cal_st == CAL_RUN) begin
         next_st.run_len = st.run_len + 16'h0001;
      end

      // decoded line-side targets
      next_st.dct_target_mv =
         DCT_MV[next_st.term.line_voltage_adjust];
      next_st.min_loop_ma =
         MIN_LOOP_MA[next_st.term.min_loop_current_sel];
      next_st.loop_limit_ma = next_st.term.current_limit_enable
         ? CURRENT_LIMIT_ENABLE_MA : NO_LIMIT_MA;

      // measurement flags and polarity detection
      next_st.polarity_reversal = 1'b0;
      if (meas_update) begin
         next_st.loop_current_low =
            (meas.loop_current_value == ZERO_BYTE);
         next_st.line_absent =
            (meas.line_voltage_value == ZERO_BYTE);
         next_st.last_sign = meas.line_voltage_value[7];
         next_st.have_sample = 1'b1;
         next_st.polarity_reversal = st.have_sample
            && (meas.line_voltage_value[7] != st.last_sign);
      end

      // register read answer, one cycle after the strobe
      next_st.rsp.valid = req.rd;
      next_st.rsp.rdata = ZERO_BYTE;
      if (req.rd) begin
         case (req.addr)
            ADDR_CAL: next_st.rsp.rdata = cal_rd;
            ADDR_TERM: next_st.rsp.rdata = term_rd;
            ADDR_LOOP: begin
               next_st.rsp.rdata =
                  meas.loop_current_value;
            end
            ADDR_VOLT: begin
               next_st.rsp.rdata =
                  meas.line_voltage_value;
            end
            default: next_st.rsp.rdata = ZERO_BYTE;
         endcase
      end
   end

   // ===========================================================
   // state register
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st <= '0;
         st.cal_st <= CAL_IDLE;
         st.auto_pending <= 1'b1;
         st.cal_trim_value <= TRIM_RESET;
         st.term <= dltr_term_t'(TERM_RESET[5:0]);
         st.dct_target_mv <= DCT_MV[0];
         st.min_loop_ma <= MIN_LOOP_MA[0];
         st.loop_limit_ma <= NO_LIMIT_MA;
         st.loop_current_low <= 1'b1;
         st.line_absent <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ===========================================================
   // outputs from flops; cal_run is decoded from the cal_st flops
   assign rsp = st.rsp;
   assign term = st.term;
   assign dct_target_mv = st.dct_target_mv;
   assign min_loop_ma = st.min_loop_ma;
   assign loop_limit_ma = st.loop_limit_ma;
   assign cal_run = (st.cal_st == CAL_RUN);
   assign cal_trim_value = st.cal_trim_value;
   assign loop_current_low = st.loop_current_low;
   assign line_absent = st.line_absent;
   assign polarity_reversal = st.polarity_reversal;

   // ===========================================================
   // checks
   chk_busy_readback: assert property (
      @(posedge core_clk) disable iff (!resetn)
      req.rd && req.addr == ADDR_CAL
      |=> rsp.rdata[CAL_BUSY_BIT] == $past(cal_run))
      else $error("busy bit does not match calibration state");

   chk_manual_start: assert property (
      @(posedge core_clk) disable iff (!resetn)
      man_rise && !cal_run |=> cal_run [*2])
      else $error("manual request did not start calibration");

   chk_cal_length: assert property (
      @(posedge core_clk) disable iff (!resetn)
      cal_run |-> st.run_len <= CAL_LAST)
      else $error("calibration runs too long");

   chk_cal_end: assert property (
      @(posedge core_clk) disable iff (!resetn)
      $fell(cal_run) |-> $past(st.run_len) == CAL_LAST)
      else $error("calibration ended at the wrong count");

   chk_cal_disabled: assert property (
      @(posedge core_clk) disable iff (!resetn)
      st.cal_disable && !wr_cal && !cal_run |=> !cal_run)
      else $error("calibration started while disabled");

   chk_rsvd_ignored: assert property (
      @(posedge core_clk) disable iff (!resetn)
      wr_cal && !req.wdata[CAL_MAN_BIT] && cal_run
      && req.wdata[CAL_RSVD_BIT]
      |=> cal_run || $past(st.run_len) == CAL_LAST)
      else $error("reserved bit disturbed calibration");

   chk_dct_target: assert property (
      @(posedge core_clk) disable iff (!resetn)
      ##1 dct_target_mv == DCT_MV[term.line_voltage_adjust])
      else $error("pin target does not follow voltage code");

   chk_min_loop: assert property (
      @(posedge core_clk) disable iff (!resetn)
      ##1 min_loop_ma == MIN_LOOP_MA[term.min_loop_current_sel])
      else $error("minimum current does not follow code");

   chk_limit_cap: assert property (
      @(posedge core_clk) disable iff (!resetn)
      wr_term |=> (loop_limit_ma == CURRENT_LIMIT_ENABLE_MA)
      == $past(req.wdata[TERM_CURRENT_LIMIT_ENABLE_BIT]))
      else $error("current limit does not follow enable");

   chk_term_bits: assert property (
      @(posedge core_clk) disable iff (!resetn)
      wr_term |=> term.dc_impedance_sel
      == $past(req.wdata[TERM_DCR_BIT]))
      else $error("impedance select not stored");

   chk_volt_read: assert property (
      @(posedge core_clk) disable iff (!resetn)
      req.rd && req.addr == ADDR_VOLT
      |=> rsp.valid && rsp.rdata == $past(meas.line_voltage_value))
      else $error("line voltage read wrong");

   chk_polarity_flag: assert property (
      @(posedge core_clk) disable iff (!resetn)
      meas_update && st.have_sample
      && meas.line_voltage_value[7] != st.last_sign
      |=> polarity_reversal ##1 !polarity_reversal || meas_update)
      else $error("sign change not flagged once");

   chk_ro_writes: assert property (
      @(posedge core_clk) disable iff (!resetn)
      req.wr && req.addr == ADDR_LOOP
      |=> $stable(meas.loop_current_value) || meas_update)
      else $error("write disturbed loop current value");

   chk_trim_store: assert property (
      @(posedge core_clk) disable iff (!resetn)
      wr_cal |=> cal_trim_value
      == $past(req.wdata[CAL_TRIM_LSB +: CAL_TRIM_W]))
      else $error("trim bits not stored as written");

   chk_loop_read: assert property (
      @(posedge core_clk) disable iff (!resetn)
      req.rd && req.addr == ADDR_LOOP
      |=> rsp.valid && rsp.rdata == $past(meas.loop_current_value))
      else $error("loop current read wrong");

   chk_loop_low: assert property (
      @(posedge core_clk) disable iff (!resetn)
      meas_update |=> loop_current_low
      == ($past(meas.loop_current_value) == ZERO_BYTE))
      else $error("low loop current flag wrong");

   chk_line_absent: assert property (
      @(posedge core_clk) disable iff (!resetn)
      meas_update |=> line_absent
      == ($past(meas.line_voltage_value) == ZERO_BYTE))
      else $error("line absent flag wrong");

endmodule // dltr_regs

/* dltr_regs_test.sv */
`timescale 1ns/1ps
// ===========================================================
// self-checking bench for the line termination register bank
module dltr_regs_test
   import dltr_pkg::*;
;
   // ===========================================================
   // stimulus and observed signals
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   dltr_req_t req = '0;
   dltr_rsp_t rsp;
   logic meas_toggle = 1'b0;
   dltr_meas_t meas_raw = '0;
   dltr_term_t term;
   logic [11:0] dct_target_mv;
   logic [4:0] min_loop_ma;
   logic [6:0] loop_limit_ma;
   logic cal_run;
   logic [3:0] cal_trim_value;
   logic loop_current_low;
   logic line_absent;
   logic polarity_reversal;
   int miscompares = 0;
   int total_checks = 0;
   logic [7:0] rd_val;

   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;

   // ===========================================================
   // design under test, short calibration for a quick run
   dltr_regs #(.CAL_CYCLES(8)) dut (
      .core_clk(core_clk),
      .resetn(resetn),
      .req(req),
      .rsp(rsp),
      .meas_toggle(meas_toggle),
      .meas_raw(meas_raw),
      .term(term),
      .dct_target_mv(dct_target_mv),
      .min_loop_ma(min_loop_ma),
      .loop_limit_ma(loop_limit_ma),
      .cal_run(cal_run),
      .cal_trim_value(cal_trim_value),
      .loop_current_low(loop_current_low),
      .line_absent(line_absent),
      .polarity_reversal(polarity_reversal)
   );

   // ===========================================================
   // shared helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one write strobe, returns at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge core_clk);
      req <= '0;
   endtask

   // one read strobe, answer sampled in the cycle after the take edge
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge core_clk);
      req <= '0;
      #1;
      chk({15'h0000, rsp.valid}, 16'h0001);
      rd_val = rsp.rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk({8'h00, rd_val}, {8'h00, exp});
   endtask

   // reset held two edges; optionally disable calibration at once
   task automatic do_reset(input logic dis);
      @(posedge core_clk);
      resetn <= 1'b0;
      req <= '0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      if (dis) begin
         req <= '{rd: 1'b0, wr: 1'b1, addr: ADDR_CAL, wdata: 8'h28};
      end
      @(posedge core_clk);
      req <= '0;
   endtask

   // ===========================================================
   // scenarios
   task automatic t_autocal;
      do_reset(1'b0);
      repeat (3) @(posedge core_clk);
      #1;
      chk({15'h0000, cal_run}, 16'h0001);
      rd(ADDR_CAL);
      chk({15'h0000, rd_val[7]}, 16'h0001);
      repeat (10) @(posedge core_clk);
      rd(ADDR_CAL);
      chk({15'h0000, rd_val[7]}, 16'h0000);
      $display("done: auto calibration");
   endtask

   task automatic t_defaults;
      int n;
      do_reset(1'b1);
      n = 0;
      repeat (12) begin
         @(posedge core_clk);
         #1;
         if (cal_run !== 1'b0) n++;
      end
      chk(16'(n), 16'h0000);
      chk({10'h000, term}, 16'h0000);
      chk({4'h0, dct_target_mv}, 16'h0C1C);
      chk({11'h000, min_loop_ma}, 16'h000A);
      chk({9'h000, loop_limit_ma}, 16'h0000);
      chk({14'h0000, loop_current_low, line_absent},
         16'h0003);
      chk({12'h000, cal_trim_value}, {12'h000, TRIM_RESET});
      rchk(ADDR_CAL, 8'h28);
      rchk(ADDR_TERM, 8'h00);
      rchk(ADDR_RSVD27, 8'h00);
      rchk(ADDR_LOOP, 8'h00);
      rchk(ADDR_VOLT, 8'h00);
      rchk(8'h20, 8'h00);
      $display("done: reset values");
   endtask

   task automatic t_manual;
      wr(ADDR_CAL, 8'h78);
      #1;
      chk({15'h0000, cal_run}, 16'h0001);
      rd(ADDR_CAL);
      chk({12'h000, rd_val[7:4]}, 16'h000F);
      wr(ADDR_CAL, {4'h3, rd_val[3:0]});
      repeat (10) @(posedge core_clk);
      wr(ADDR_CAL, 8'hB8);
      rd(ADDR_CAL);
      chk({12'h000, rd_val[7:4]}, 16'h0003);
      $display("done: manual calibration");
   endtask

   task automatic t_term;
      logic [1:0] c;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         d = {c, c, 2'b00, c[0], c[1]};
         wr(ADDR_TERM, d);
         #1;
         chk({10'h000, term},
            {10'h000, c, c, c[0], c[1]});
         @(posedge core_clk);
         #1;
         chk({4'h0, dct_target_mv}, {4'h0, DCT_MV[i]});
         chk({11'h000, min_loop_ma},
            {11'h000, MIN_LOOP_MA[i]});
         chk({9'h000, loop_limit_ma},
            {9'h000, c[0] ? CURRENT_LIMIT_ENABLE_MA : NO_LIMIT_MA});
         chk({15'h0000, term.dc_impedance_sel},
            {15'h0000, c[1]});
         rchk(ADDR_TERM, d);
      end
      $display("done: dc termination");
   endtask

   // one measurement pair, then flags, reads and two write attempts
   task automatic meas(input logic [7:0] l, input logic [7:0] v,
                       input int pulses);
      int n;
      @(posedge core_clk);
      meas_raw <= '{loop_current_value: l, line_voltage_value: v};
      @(posedge core_clk);
      meas_toggle <= ~meas_toggle;
      n = 0;
      repeat (8) begin
         @(posedge core_clk);
         #1;
         if (polarity_reversal === 1'b1) n++;
      end
      chk(16'(n), 16'(pulses));
      chk({15'h0000, loop_current_low},
         {15'h0000, l == 8'h00});
      chk({15'h0000, line_absent}, {15'h0000, v == 8'h00});
      rchk(ADDR_LOOP, l);
      rchk(ADDR_VOLT, v);
      wr(ADDR_LOOP, 8'hFF);
      wr(ADDR_VOLT, 8'h7F);
      rchk(ADDR_LOOP, l);
      rchk(ADDR_VOLT, v);
   endtask

   task automatic t_meas;
      meas(8'h2D, 8'h30, 0);
      meas(8'h2D, 8'hD0, 1);
      meas(8'h12, 8'hCF, 0);
      meas(8'h00, 8'h00, 1);
      $display("done: measurements");
   endtask

   // ===========================================================
   // verdict and run control
   task automatic tally_and_finish;
      $display("checks %0d, miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      t_autocal();
      t_defaults();
      t_manual();
      t_term();
      t_meas();
      tally_and_finish();
   end

   // watchdog, well beyond the roughly 180 cycles the run needs
   initial begin
      repeat (4000) @(posedge core_clk);
      miscompares++;
      tally_and_finish();
   end
endmodule // dltr_regs_test
